// ==== design/dio_map.svh ====
// constants for the digital i/o filter and output monitor block
// assumes a 10 MHz clock and the cyclic network exchange of the top module
// Function
// - unfiltered inputs captured at fixed cycle offset, sent in same cycle
// - filtered inputs captured at fixed cycle offset, sent in same cycle
// - filter runs free of network cycle, 200 us steps, drift at most 50 us; here the free sample tick lets drift reach a whole 200 us step
// - input n appears at bit n-1 of the input byte
// - one filter value for all eight inputs, 100 us per count
// - inputs sampled every 200 us; even filter values advised
// - filter value zero disables filtering; zero is the default
// - value 250 gives 25 ms; larger values act as 250
// - switching states reach outputs at fixed offset under 60 us after sync point
// - output n follows bit n-1; 1 on, 0 off
// - actual output state compared with driver control signal
// - command change restarts monitoring of that channel only
// - any monitoring status change raises an error notification
// - status bit 1 on overload, no supply when on, voltage when off
// - block occupies one digital logical slot
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

`define CLK_PERIOD_NS 100
`define N_INPUTS 8
`define N_OUTPUTS 4

// acyclic register numbers
`define REG_INPUT_STATE 8'h00
`define REG_OUTPUT_SWITCH 8'h02
`define REG_FILTER_CFG 8'h12
`define REG_OUTPUT_STATUS 8'h1e

// reset values and limits
`define FILTER_CFG_RST 8'h00
`define FILTER_CFG_MAX 8'hfa
`define OUTPUT_SWITCH_RST 8'h00
`define LOGICAL_SLOTS 8'h01

// timing
`define FILTER_UNIT_US 100
`define SAMPLE_PERIOD_US 200
`define SAMPLE_CYC ((`SAMPLE_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define FILTER_JITTER_MAX_US 50
`define IN_CAPTURE_OFFSET_NS 1000
`define IN_CAPTURE_CYC ((`IN_CAPTURE_OFFSET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUT_APPLY_MAX_US 60
`define OUT_APPLY_OFFSET_NS 2000
`define OUT_APPLY_CYC ((`OUT_APPLY_OFFSET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MON_SETTLE_US 200
`define MON_SETTLE_CYC ((`MON_SETTLE_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== design/dio_pkg.sv ====
// types shared by the digital i/o block
// assumes the constants of dio_map.svh
package dio_pkg;

  // acyclic request from the network side
  typedef struct packed {
    logic write;
    logic [7:0] reg_num;
    logic [7:0] wdata;
  } acyc_req_s;

  // acyclic answer
  typedef struct packed {
    logic err;
    logic [7:0] rdata;
  } acyc_rsp_s;

  // delay timer states
  typedef enum logic {tmr_idle, tmr_run} timer_e;

endpackage

// ==== design/dio_input_filter.sv ====
// per-input debounce filter for the eight inputs
// assumes synchronised inputs and a one-cycle sample tick
`timescale 1ns/10ps
module dio_input_filter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] raw_i,
  input wire logic tick_i,
  input wire logic [6:0] need_i,
  output logic [7:0] filt_o
);

  logic [7:0] filt_r;
  logic [6:0] cnt_r [8];

  // a level change is taken only after need_i equal samples
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        cnt_r[i] <= 7'h00;
      end
    end else if (need_i == 7'h00) begin
      filt_r <= raw_i;
      for (int i = 0; i < 8; i++) begin
        cnt_r[i] <= 7'h00;
      end
    end else if (tick_i) begin
      for (int i = 0; i < 8; i++) begin
        if (raw_i[i] != filt_r[i]) begin
          if (cnt_r[i] + 7'h01 >= need_i) begin
            filt_r[i] <= raw_i[i];
            cnt_r[i] <= 7'h00;
          end else begin
            cnt_r[i] <= cnt_r[i] + 7'h01;
          end
        end else begin
          cnt_r[i] <= 7'h00; // bounce restarts the count
        end
      end
    end
  end

  assign filt_o = filt_r;

endmodule // dio_input_filter

// ==== design/dio_output_monitor.sv ====
// per-channel monitor of the four outputs against their driver control
// assumes synchronised feedback and fault inputs
`timescale 1ns/10ps
`include "dio_map.svh"
module dio_output_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] target_i,
  input wire logic [3:0] fb_i,
  input wire logic [3:0] ovl_i,
  input wire logic supply_ok_i,
  output logic [3:0] status_o
);

  logic [3:0] tgt_prev_r;
  logic [3:0] status_r;
  logic [11:0] settle_r [4];
  logic [3:0] fault;
  logic [3:0] changed;

  // error terms; a short or missing supply shows also as a level mismatch
  assign fault = ovl_i | (target_i & {4{~supply_ok_i}}) | (target_i ^ fb_i);
  assign changed = target_i ^ tgt_prev_r;

  // settle time hides the switching edge itself
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgt_prev_r <= 4'h0;
      status_r <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        settle_r[i] <= 12'h000;
      end
    end else begin
      tgt_prev_r <= target_i;
      for (int i = 0; i < 4; i++) begin
        if (changed[i]) begin
          settle_r[i] <= 12'(`MON_SETTLE_CYC - 1);
          status_r[i] <= 1'b0;
        end else if (settle_r[i] != 12'h000) begin
          settle_r[i] <= settle_r[i] - 12'h001;
        end else begin
          status_r[i] <= fault[i];
        end
      end
    end
  end

  assign status_o = status_r;

endmodule // dio_output_monitor

// ==== design/digital_io_filter_monitor.sv ====
// top of the mixed digital i/o block: filter, cyclic and acyclic exchange
// assumes the network side runs on clk_i; pins arrive unsynchronised
`timescale 1ns/10ps
`include "dio_map.svh"
module digital_io_filter_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  // pins
  input wire logic [7:0] din_i,
  input wire logic [3:0] out_fb_i,
  input wire logic [3:0] out_ovl_i,
  input wire logic io_supply_ok_i,
  output logic [3:0] dout_o,
  // cyclic exchange
  input wire logic net_cycle_i,
  input wire logic network_output_sync_point_i,
  input wire logic [7:0] output_switch_byte_i,
  output logic [7:0] input_level_byte_o,
  output logic [7:0] output_monitor_byte_o,
  output logic cyc_in_valid_o,
  // acyclic exchange
  input wire logic acyc_valid_i,
  input wire dio_pkg::acyc_req_s acyc_req_i,
  output logic acyc_ack_o,
  output dio_pkg::acyc_rsp_s acyc_rsp_o,
  // notifications
  output logic error_evt_o,
  output logic [7:0] logical_slots_o
);

  // filter value to number of 200 us samples
  function automatic logic [6:0] filter_samples(input logic [7:0] cfg);
    logic [7:0] c;
    c = (cfg > `FILTER_CFG_MAX) ? `FILTER_CFG_MAX : cfg;
    if (c == 8'h00) begin
      filter_samples = 7'h00;
    end else if (c < 8'h02) begin
      filter_samples = 7'h01;
    end else begin
      filter_samples = c[7:1];
    end
  endfunction

  // pin synchronisers
  logic [16:0] pins_s1_r;
  logic [16:0] pins_s2_r;
  logic [7:0] din_s;
  logic [3:0] fb_s;
  logic [3:0] ovl_s;
  logic supply_s;

  // free sample clock
  logic [11:0] sample_cnt_r;
  logic sample_tick;

  // configuration and switching
  logic [7:0] filter_cfg_r;
  logic [7:0] switch_r;
  logic [6:0] need;
  logic [7:0] filt;
  logic [7:0] in_live;
  logic [3:0] status;

  // capture and apply timers
  dio_pkg::timer_e cap_state_r;
  dio_pkg::timer_e cap_state_nxt;
  logic [11:0] cap_cnt_r;
  logic [11:0] cap_cnt_nxt;
  logic cap_fire;
  dio_pkg::timer_e app_state_r;
  dio_pkg::timer_e app_state_nxt;
  logic [11:0] app_cnt_r;
  logic [11:0] app_cnt_nxt;
  logic app_fire;

  // output registers
  logic [3:0] dout_r;
  logic [7:0] in_byte_r;
  logic [7:0] mon_byte_r;
  logic cyc_valid_r;
  logic ack_r;
  dio_pkg::acyc_rsp_s rsp_r;
  dio_pkg::acyc_rsp_s rsp_nxt;
  logic err_evt_r;
  logic [3:0] status_prev_r;
  logic [7:0] slots_r;

  // acyclic decode
  logic hit_in;
  logic hit_sw;
  logic hit_cfg;
  logic hit_stat;
  logic rd_ok;
  logic wr_ok;
  logic wr_sw;
  logic wr_cfg;

  // two flops on every pin before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_s1_r <= 17'h00000;
      pins_s2_r <= 17'h00000;
    end else begin
      pins_s1_r <= {io_supply_ok_i, out_ovl_i, out_fb_i, din_i};
      pins_s2_r <= pins_s1_r;
    end
  end

  assign din_s = pins_s2_r[7:0];
  assign fb_s = pins_s2_r[11:8];
  assign ovl_s = pins_s2_r[15:12];
  assign supply_s = pins_s2_r[16];

  // sample tick free of the network cycle; capture drift follows from it
  always_ff @(posedge clk_i) begin
    if (rst_i || sample_tick) begin
      sample_cnt_r <= 12'(`SAMPLE_CYC - 1);
    end else begin
      sample_cnt_r <= sample_cnt_r - 12'h001;
    end
  end

  assign sample_tick = (sample_cnt_r == 12'h000);

  assign need = filter_samples(filter_cfg_r);

  dio_input_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(din_s),
    .tick_i(sample_tick),
    .need_i(need),
    .filt_o(filt)
  );

  // raw levels when the filter is off, filtered ones otherwise
  assign in_live = (need == 7'h00) ? din_s : filt;

  dio_output_monitor u_monitor (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .target_i(dout_r),
    .fb_i(fb_s),
    .ovl_i(ovl_s),
    .supply_ok_i(supply_s),
    .status_o(status)
  );

  // input capture at a fixed offset after each network cycle start
  always_comb begin
    cap_state_nxt = cap_state_r;
    cap_cnt_nxt = cap_cnt_r;
    unique case (cap_state_r)
      dio_pkg::tmr_idle: begin
        if (net_cycle_i) begin
          cap_state_nxt = dio_pkg::tmr_run;
          cap_cnt_nxt = 12'(`IN_CAPTURE_CYC - 1);
        end
      end
      dio_pkg::tmr_run: begin
        if (net_cycle_i) begin
          cap_cnt_nxt = 12'(`IN_CAPTURE_CYC - 1);
        end else if (cap_cnt_r == 12'h000) begin
          cap_state_nxt = dio_pkg::tmr_idle;
        end else begin
          cap_cnt_nxt = cap_cnt_r - 12'h001;
        end
      end
    endcase
  end

  assign cap_fire = (cap_state_r == dio_pkg::tmr_run) && !net_cycle_i && (cap_cnt_r == 12'h000);

  // output apply at a fixed offset after the sync point
  always_comb begin
    app_state_nxt = app_state_r;
    app_cnt_nxt = app_cnt_r;
    unique case (app_state_r)
      dio_pkg::tmr_idle: begin
        if (network_output_sync_point_i) begin
          app_state_nxt = dio_pkg::tmr_run;
          app_cnt_nxt = 12'(`OUT_APPLY_CYC - 1);
        end
      end
      dio_pkg::tmr_run: begin
        if (app_cnt_r == 12'h000) begin
          app_state_nxt = dio_pkg::tmr_idle;
        end else begin
          app_cnt_nxt = app_cnt_r - 12'h001;
        end
      end
    endcase
  end

  // a sync point during the run is ignored; the offset stays fixed
  assign app_fire = (app_state_r == dio_pkg::tmr_run) && (app_cnt_r == 12'h000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_state_r <= dio_pkg::tmr_idle;
      cap_cnt_r <= 12'h000;
      app_state_r <= dio_pkg::tmr_idle;
      app_cnt_r <= 12'h000;
    end else begin
      cap_state_r <= cap_state_nxt;
      cap_cnt_r <= cap_cnt_nxt;
      app_state_r <= app_state_nxt;
      app_cnt_r <= app_cnt_nxt;
    end
  end

  // acyclic register decode by register number
  assign hit_in = (acyc_req_i.reg_num == `REG_INPUT_STATE);
  assign hit_sw = (acyc_req_i.reg_num == `REG_OUTPUT_SWITCH);
  assign hit_cfg = (acyc_req_i.reg_num == `REG_FILTER_CFG);
  assign hit_stat = (acyc_req_i.reg_num == `REG_OUTPUT_STATUS);
  assign rd_ok = !acyc_req_i.write && (hit_in || hit_stat);
  assign wr_ok = acyc_req_i.write && (hit_sw || hit_cfg);
  assign wr_sw = acyc_valid_i && acyc_req_i.write && hit_sw;
  assign wr_cfg = acyc_valid_i && acyc_req_i.write && hit_cfg;

  // reads of write-only, writes of read-only registers and unknown numbers answer with err
  always_comb begin
    rsp_nxt.err = !(rd_ok || wr_ok);
    rsp_nxt.rdata = 8'h00;
    if (rd_ok && hit_in) begin
      rsp_nxt.rdata = in_live;
    end else if (rd_ok && hit_stat) begin
      rsp_nxt.rdata = {4'h0, status};
    end
  end

  // filter value is clamped on write so reads of state stay simple
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filter_cfg_r <= `FILTER_CFG_RST;
    end else if (wr_cfg) begin
      filter_cfg_r <= (acyc_req_i.wdata > `FILTER_CFG_MAX) ? `FILTER_CFG_MAX
                                                          : acyc_req_i.wdata;
    end
  end

  // cyclic byte at the sync point, acyclic write in any other cycle; upper bits dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_r <= `OUTPUT_SWITCH_RST;
    end else if (network_output_sync_point_i) begin
      switch_r <= {4'h0, output_switch_byte_i[3:0]};
    end else if (wr_sw) begin
      switch_r <= {4'h0, acyc_req_i.wdata[3:0]};
    end
  end

  // drivers change only at the apply point
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout_r <= 4'h0;
    end else if (app_fire) begin
      dout_r <= switch_r[3:0];
    end
  end

  // cyclic input data, one pulse per network cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_byte_r <= 8'h00;
      mon_byte_r <= 8'h00;
      cyc_valid_r <= 1'b0;
    end else begin
      cyc_valid_r <= cap_fire;
      if (cap_fire) begin
        in_byte_r <= in_live;
        mon_byte_r <= {4'h0, status};
      end
    end
  end

  // acyclic answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rsp_r <= '0;
    end else begin
      ack_r <= acyc_valid_i;
      if (acyc_valid_i) begin
        rsp_r <= rsp_nxt;
      end
    end
  end

  // any edge of any status bit is reported
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_prev_r <= 4'h0;
      err_evt_r <= 1'b0;
    end else begin
      status_prev_r <= status;
      err_evt_r <= (status != status_prev_r);
    end
  end

  // slot count is fixed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slots_r <= `LOGICAL_SLOTS;
    end else begin
      slots_r <= `LOGICAL_SLOTS;
    end
  end

  assign dout_o = dout_r;
  assign input_level_byte_o = in_byte_r;
  assign output_monitor_byte_o = mon_byte_r;
  assign cyc_in_valid_o = cyc_valid_r;
  assign acyc_ack_o = ack_r;
  assign acyc_rsp_o = rsp_r;
  assign error_evt_o = err_evt_r;
  assign logical_slots_o = slots_r;

endmodule // digital_io_filter_monitor

// ==== test/dio_bus_ctrl.sv ====
// bus controller model: cycle pulse, output sync point, switching byte
// assumes the bench changes sw_byte_i well away from the sync point
`timescale 1ns/10ps
module dio_bus_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sw_byte_i,
  output logic net_cycle_o,
  output logic sync_o,
  output logic [7:0] byte_o
);
  int cnt = 0;
  logic r;
  // quiet outputs from time zero
  initial begin
    net_cycle_o = 1'b0;
    sync_o = 1'b0;
    byte_o = 8'h00;
  end
  // 200 us cycle, so updates come every cycle even when filtered
  always @(posedge clk_i) begin
    r = rst_i;
    #10;
    cnt = r ? 0 : (cnt + 1) % 2000;
    net_cycle_o = !r && cnt == 1;
    sync_o = !r && cnt == 500;
    byte_o = sync_o ? sw_byte_i : ~byte_o; // scrambled outside the sync point
  end
endmodule // dio_bus_ctrl

// ==== test/dio_checker_props.sv ====
// concurrent checks on the top ports of the digital i/o block
// assumes clk_i only and rst_i synchronous, active high
`timescale 1ns/10ps
module dio_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic net_cycle_i,
  input wire logic network_output_sync_point_i,
  input wire logic [7:0] output_switch_byte_i,
  input wire logic [7:0] input_level_byte_o,
  input wire logic [7:0] output_monitor_byte_o,
  input wire logic cyc_in_valid_o,
  input wire logic [3:0] dout_o,
  input wire logic acyc_valid_i,
  input wire logic acyc_ack_o,
  input wire dio_pkg::acyc_rsp_s acyc_rsp_o,
  input wire logic [7:0] logical_slots_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [3:0] sw_lo;
  // only the low nibble drives channels
  assign sw_lo = output_switch_byte_i[3:0];
  a_in_capture_due:
    assert property (net_cycle_i |-> ##11 cyc_in_valid_o) else $error("capture missed");
  a_in_capture_time:
    assert property (cyc_in_valid_o |-> $past(net_cycle_i, 11)) else $error("capture early");
  a_in_bytes_hold:
    assert property (!cyc_in_valid_o |-> $stable(input_level_byte_o)
      && $stable(output_monitor_byte_o)) else $error("cyclic bytes moved");
  a_out_apply_time:
    assert property ($changed(dout_o) |-> $past(network_output_sync_point_i, 21))
    else $error("outputs moved off the apply offset");
  a_out_apply_value:
    assert property (network_output_sync_point_i |-> ##21 dout_o == $past(sw_lo, 21))
    else $error("outputs not the switching byte");
  a_acyc_answer_due:
    assert property (acyc_valid_i |=> acyc_ack_o) else $error("no acyclic answer");
  a_acyc_rsp_hold:
    assert property (!acyc_ack_o |-> $stable(acyc_rsp_o)) else $error("answer moved");
  a_slot_count:
    assert property (logical_slots_o == 8'h01) else $error("slot count wrong");
endmodule // dio_checker
bind digital_io_filter_monitor dio_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .net_cycle_i(net_cycle_i), .network_output_sync_point_i(network_output_sync_point_i),
  .output_switch_byte_i(output_switch_byte_i), .input_level_byte_o(input_level_byte_o),
  .output_monitor_byte_o(output_monitor_byte_o), .cyc_in_valid_o(cyc_in_valid_o),
  .dout_o(dout_o), .acyc_valid_i(acyc_valid_i), .acyc_ack_o(acyc_ack_o),
  .acyc_rsp_o(acyc_rsp_o), .logical_slots_o(logical_slots_o));

// ==== test/tb_digital_io_filter_monitor.sv ====
// self-checking bench for the digital i/o block
// assumes the bus controller model dio_bus_ctrl on the cyclic side
`timescale 1ns/10ps
module tb_digital_io_filter_monitor;
  logic clk, rst, io_ok, a_valid, a_ack, cyc_valid, evt, net_cycle, sync_pt;
  logic [7:0] din, sw, sw_cyc, in_byte, mon_byte, slots;
  logic [3:0] ovl, flip, fb, dout;
  dio_pkg::acyc_req_s a_req;
  dio_pkg::acyc_rsp_s a_rsp;
  int n_fail, n_checks, n_evt;
  // healthy loads echo the driver unless a channel is forced
  assign fb = dout ^ flip;
  digital_io_filter_monitor u_dut (.clk_i(clk), .rst_i(rst), .din_i(din), .out_fb_i(fb),
    .out_ovl_i(ovl), .io_supply_ok_i(io_ok), .dout_o(dout), .net_cycle_i(net_cycle),
    .network_output_sync_point_i(sync_pt), .output_switch_byte_i(sw_cyc),
    .input_level_byte_o(in_byte), .output_monitor_byte_o(mon_byte),
    .cyc_in_valid_o(cyc_valid), .acyc_valid_i(a_valid), .acyc_req_i(a_req),
    .acyc_ack_o(a_ack), .acyc_rsp_o(a_rsp), .error_evt_o(evt), .logical_slots_o(slots));
  dio_bus_ctrl u_bus (.clk_i(clk), .rst_i(rst), .sw_byte_i(sw), .net_cycle_o(net_cycle),
    .sync_o(sync_pt), .byte_o(sw_cyc));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count error notices as they pulse
  always @(posedge clk) begin
    if (evt === 1'b1) n_evt++;
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one acyclic transfer; read data compared only on a good read
  task automatic acyc(logic w, logic [7:0] r, logic [7:0] d, logic e, logic [7:0] x);
    a_valid = 1'b1;
    a_req = '{w, r, d};
    tick(1);
    a_valid = 1'b0;
    chk("ack", 8'h01, {7'h00, a_ack});
    chk("err", {7'h00, e}, {7'h00, a_rsp.err});
    if (!w && !e) chk("rdata", x, a_rsp.rdata);
    tick(1);
  endtask
  // bounded wait for the cyclic capture pulse
  task automatic wait_cyc();
    int i;
    i = 0;
    while (cyc_valid !== 1'b1 && i < 3000) begin
      tick(1);
      i++;
    end
    chk("capture pulse", 8'h01, {7'h00, cyc_valid});
    tick(1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog: about twice the expected run
  initial begin
    #10000000;
    n_fail++;
    wrap_up();
  end
  // register table, then cyclic, monitor and filter tests
  initial begin
    logic [7:0] regs [8] = '{8'h00, 8'h02, 8'h00, 8'h12, 8'h1e, 8'h05, 8'h02, 8'h12};
    logic [7:0] wr = 8'hd4;
    logic [7:0] er = 8'h3e;
    logic [3:0] cov [5] = '{4'h0, 4'h2, 4'h0, 4'h0, 4'h4};
    logic [3:0] cfl [5] = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h0};
    logic csup [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    int exp_st, prev, ev0;
    rst = 1'b1;
    {din, sw, ovl, flip, a_valid} = '0;
    io_ok = 1'b1;
    a_req = '0;
    {n_fail, n_checks, n_evt} = '0;
    void'($urandom(15601));
    tick(16);
    rst = 1'b0;
    chk("slots", 8'h01, slots);
    chk("outputs", 8'h00, {4'h0, dout});
    din = 8'($urandom);
    tick(4);
    for (int i = 0; i < 8; i++) acyc(wr[i], regs[i], 8'h00, er[i], din);
    $display("register access done");
    for (int k = 0; k < 4; k++) begin
      wait_cyc();
      chk("dout", {4'h0, sw[3:0]}, {4'h0, dout});
      chk("input byte", din, in_byte);
      din = 8'($urandom);
      sw = 8'($urandom);
    end
    $display("cyclic exchange done");
    sw = 8'h05;
    wait_cyc();
    wait_cyc();
    prev = 0;
    for (int c = 0; c < 5; c++) begin
      ev0 = n_evt;
      ovl = cov[c];
      flip = cfl[c];
      io_ok = csup[c];
      exp_st = cov[c] | (csup[c] ? 0 : 5) | cfl[c];
      tick(30);
      acyc(1'b0, 8'h1e, 8'h00, 1'b0, 8'(exp_st));
      chk("error notice", 8'(exp_st != prev), 8'(n_evt != ev0));
      prev = exp_st;
    end
    sw = 8'h04;
    wait_cyc();
    chk("status byte", 8'h04, mon_byte);
    acyc(1'b0, 8'h1e, 8'h00, 1'b0, 8'h04);
    ovl = 4'h0;
    $display("output monitor done");
    acyc(1'b1, 8'h12, 8'h08, 1'b0, 8'h00);
    din = ~din;
    tick(5000);
    acyc(1'b0, 8'h00, 8'h00, 1'b0, ~din);
    tick(5000);
    acyc(1'b0, 8'h00, 8'h00, 1'b0, din);
    wait_cyc();
    chk("filtered byte", din, in_byte);
    acyc(1'b1, 8'h12, 8'hff, 1'b0, 8'h00);
    din = ~din;
    tick(20000);
    acyc(1'b0, 8'h00, 8'h00, 1'b0, ~din);
    // odd value 1 still needs one whole 200 us sample
    acyc(1'b1, 8'h12, 8'h01, 1'b0, 8'h00);
    tick(2010);
    acyc(1'b0, 8'h00, 8'h00, 1'b0, din);
    acyc(1'b1, 8'h12, 8'h00, 1'b0, 8'h00);
    tick(4);
    acyc(1'b0, 8'h00, 8'h00, 1'b0, din);
    $display("input filter done");
    wrap_up();
  end
endmodule // tb_digital_io_filter_monitor
